// ### hw/dms_defines.svh
// named offsets, field positions, reset values and counts of the display memory sequencer
`ifndef DMS_DEFINES_SVH
`define DMS_DEFINES_SVH

// index pointer values that pick a data register
`define DMS_IDX_RUN        3'h0
`define DMS_IDX_CLOCK      3'h1
`define DMS_IDX_PLANE      3'h2
`define DMS_IDX_GLYPH      3'h3
`define DMS_IDX_LAYOUT     3'h4

// run_control fields
`define DMS_RUN_ASYNC      0
`define DMS_RUN_SYNC       1
`define DMS_RUN_RESET      2'h3

// clock_config fields
`define DMS_CLK_DOTS8      0
`define DMS_CLK_BW         1
`define DMS_CLK_LOAD2      2
`define DMS_CLK_DIV2       3

// memory_layout fields
`define DMS_MEM_ALPHA      0
`define DMS_MEM_FULL       1
`define DMS_MEM_SEQ        2

// glyph_bank_select fields
`define DMS_GLYPH_B_LO     0
`define DMS_GLYPH_A_LO     2

// cleared values of the data registers and the index pointer
`define DMS_CLOCK_RESET    4'h0
`define DMS_PLANE_RESET    4'h0
`define DMS_GLYPH_RESET    4'h0
`define DMS_LAYOUT_RESET   3'h0
`define DMS_IDX_RESET      3'h0

// dot and memory cycle counts
`define DMS_LAST_DOT8      4'h7
`define DMS_LAST_DOT9      4'h8
`define DMS_LAST_SLOT      3'h4
`define DMS_CRT_SLOTS_HI   3'h4
`define DMS_CRT_SLOTS_LO   3'h2

// plane strobe patterns
`define DMS_PLANES_ALL     4'hf
`define DMS_PLANES_EVEN    4'h5
`define DMS_PLANES_ODD     4'ha
`define DMS_PLANES_NONE    4'h0

`endif

// ### hw/dms_pkg.sv
// state types of the display memory sequencer
package dms_pkg;

   // register file state
   typedef struct packed {
      logic [2:0] idx;
      logic [1:0] run;
      logic [3:0] clk_cfg;
      logic [3:0] mask;
      logic [3:0] glyph;
      logic [2:0] mem;
   } dms_regs_t;

   // sequencer core state
   typedef struct packed {
      logic       div_ph;
      logic [3:0] dot_cnt;
      logic [2:0] slot;
      logic       ld_ph;
      logic       dot_tick;
      logic       char_clk;
      logic       serial_load;
      logic       crt_cyc;
      logic       cpu_cyc;
      logic       cpu_wr;
      logic       cpu_ack;
      logic [3:0] ras;
      logic       b_bus_column_strobe;
      logic [1:0] a_hi;
      logic [1:0] b_hi;
      logic       hi_oe;
      logic       out_oe;
   } dms_core_t;

endpackage

// ### hw/dms_cfg_if.sv
// configuration carrier between register file and sequencer core
interface dms_cfg_if;
   logic [1:0] run;
   logic [3:0] clk_cfg;
   logic [3:0] mask;
   logic [3:0] glyph;
   logic [2:0] mem;

   modport regs (output run, clk_cfg, mask, glyph, mem);
   modport core (input run, clk_cfg, mask, glyph, mem);
endinterface

// ### hw/dms_regfile.sv
// write-only indexed register file of the display memory sequencer
`include "dms_defines.svh"

module dms_regfile (
   input  wire logic       core_clk_i,            // master clock
   input  wire logic       sys_rst_i,             // sync reset, active high
   input  wire logic       clk_en_i,              // freezes state when low
   input  wire logic       wr_stb_i,              // one-cycle host write strobe
   input  wire logic       index_select_input_i,  // 0 pointer, 1 data
   input  wire logic [7:0] wr_data_i,             // host write data
   dms_cfg_if.regs         cfg                    // stored register settings
);

   dms_pkg::dms_regs_t q, d;

   // pointer or data write; pointer is untouched by data writes
   always_comb
   begin
      d = q;
      if (wr_stb_i && !index_select_input_i)
         d.idx = wr_data_i[2:0];                                   // R1 R2
      else if (wr_stb_i)
      begin
         case (q.idx)                                              // R1 R23
            `DMS_IDX_RUN:
            begin
               d.run = wr_data_i[1:0];                             // R3
               if (!wr_data_i[`DMS_RUN_ASYNC])
                  d.glyph = `DMS_GLYPH_RESET;                      // R7
            end
            `DMS_IDX_CLOCK:  d.clk_cfg = wr_data_i[3:0];           // R8
            `DMS_IDX_PLANE:  d.mask = wr_data_i[3:0];              // R13
            `DMS_IDX_GLYPH:  d.glyph = wr_data_i[3:0];             // R15
            `DMS_IDX_LAYOUT: d.mem = wr_data_i[2:0];               // R20
            default:         d = q;                                // unmapped index ignored
         endcase
      end
   end

   // state register; sync reset brings the sequencer up running
   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
      begin
         q.idx     <= `DMS_IDX_RESET;
         q.run     <= `DMS_RUN_RESET;
         q.clk_cfg <= `DMS_CLOCK_RESET;
         q.mask    <= `DMS_PLANE_RESET;
         q.glyph   <= `DMS_GLYPH_RESET;
         q.mem     <= `DMS_LAYOUT_RESET;
      end
      else if (clk_en_i)
         q <= d;
   end

   assign cfg.run     = q.run;
   assign cfg.clk_cfg = q.clk_cfg;
   assign cfg.mask    = q.mask;
   assign cfg.glyph   = q.glyph;
   assign cfg.mem     = q.mem;

   // bank select is cleared by a write that drops the async bit
   a_glyph_clear: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      (clk_en_i && wr_stb_i && index_select_input_i && q.idx == `DMS_IDX_RUN
       && !wr_data_i[`DMS_RUN_ASYNC]) |=> q.glyph == `DMS_GLYPH_RESET) // R7
      else $error("bank select not cleared by async reset");

   // data writes leave the pointer alone
   a_index_hold: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      (clk_en_i && wr_stb_i && index_select_input_i) |=> q.idx == $past(q.idx)) // R23
      else $error("index pointer moved on data write");

endmodule

// ### hw/dms_sequencer.sv
// display memory sequencer top: dot and character clocks, cycle sharing, plane strobes
`include "dms_defines.svh"

// How it works
// R1: one address input picks pointer or data
// R2: 3-bit pointer selects target data register
// R3: pointer 00H reaches run control register
// R4: run bit 0 low clears, halts, floats
// R5: run bit 1 low halts; both high run
// R6: host halts before rewriting clock settings
// R7: run bit 0 low clears bank select
// R8: 4-bit clock config at pointer 01H
// R9: clock bit 0 picks 9 or 8 dots
// R10: clock bit 1 picks 4/5 or 2/5 CRT
// R11: clock bit 2 reloads every or alternate char
// R12: clock bit 3 divides master clock by two
// R13: plane mask gates CPU write row strobes
// R14: host keeps odd/even mask pairs equal
// R15: bank select at 03H drives B bus only
// R16: bits 1..0 pick bank, attribute low
// R17: bits 3..2 pick bank, attribute high
// R18: switching only when the two fields differ
// R19: minimum memory always selects bank zero
// R20: layout bit 0 low copies A high to B
// R21: layout bit 1 enables high address outputs
// R22: layout bit 2 low steers even/odd planes
// R23: pointer holds across repeated data writes
module dms_sequencer (
   input  wire logic       core_clk_i,            // master clock, 40 MHz
   input  wire logic       sys_rst_i,             // sync reset, active high
   input  wire logic       clk_en_i,              // freezes all state when low
   input  wire logic       wr_stb_i,              // host register write strobe
   input  wire logic       index_select_input_i,  // 0 pointer, 1 data
   input  wire logic [7:0] wr_data_i,             // host register write data
   input  wire logic       cpu_req_i,             // cpu memory access pending
   input  wire logic       cpu_we_i,              // pending access is a write
   input  wire logic       cpu_addr0_i,           // cpu address bit 0
   input  wire logic       attribute_bit3_line_i, // attribute bit 3 of the glyph
   input  wire logic [1:0] crt_high_addr_i,       // high address from CRT side
   output logic            dot_tick_o,            // one pulse per dot
   output logic            char_clk_o,            // one pulse per character
   output logic            serial_load_o,         // serializer reload pulse
   output logic            crt_cycle_o,           // memory cycle owned by CRT
   output logic            cpu_cycle_o,           // memory cycle owned by cpu
   output logic            cpu_ack_o,             // cpu access granted pulse
   output logic            plane0_row_strobe_o,   // plane 0 row strobe, high active
   output logic            plane1_row_strobe_o,   // plane 1 row strobe, high active
   output logic            plane2_row_strobe_o,   // plane 2 row strobe, high active
   output logic            plane3_row_strobe_o,   // plane 3 row strobe, high active
   output logic            b_bus_column_strobe_o, // B bus column strobe
   output logic            a_bus_high_addr_14_o,  // A bus high address bit 14
   output logic            a_bus_high_addr_15_o,  // A bus high address bit 15
   output logic            b_bus_high_addr_14_o,  // B bus high address bit 14
   output logic            b_bus_high_addr_15_o,  // B bus high address bit 15
   output logic            high_addr_oe_o,        // enable of the four high address pins
   output logic            outputs_oe_o           // enable of all other outputs
);

   localparam int NEXT_CYC = 1;

   dms_cfg_if cfg ();

   dms_pkg::dms_core_t q, d;

   logic       running;
   logic       dot_now;
   logic [3:0] last_dot;
   logic [2:0] crt_slots;
   logic [2:0] next_slot;
   logic [3:0] cpu_planes;
   logic [1:0] glyph_bank;

   dms_regfile u_regs (
      .core_clk_i           (core_clk_i),
      .sys_rst_i            (sys_rst_i),
      .clk_en_i             (clk_en_i),
      .wr_stb_i             (wr_stb_i),
      .index_select_input_i (index_select_input_i),
      .wr_data_i            (wr_data_i),
      .cfg                  (cfg)
   );

   // decoded settings used by the sequencing process
   always_comb
   begin
      running   = cfg.run[`DMS_RUN_ASYNC] && cfg.run[`DMS_RUN_SYNC];    // R5
      dot_now   = !cfg.clk_cfg[`DMS_CLK_DIV2] || q.div_ph;             // R12
      last_dot  = cfg.clk_cfg[`DMS_CLK_DOTS8] ? `DMS_LAST_DOT8 : `DMS_LAST_DOT9; // R9
      crt_slots = cfg.clk_cfg[`DMS_CLK_BW] ? `DMS_CRT_SLOTS_LO : `DMS_CRT_SLOTS_HI; // R10
      next_slot = (q.slot == `DMS_LAST_SLOT) ? 3'h0 : q.slot + 3'h1;
      // even addresses to planes 0/2, odd to 1/3, unless sequential
      if (cfg.mem[`DMS_MEM_SEQ])
         cpu_planes = `DMS_PLANES_ALL;                                 // R22
      else
         cpu_planes = cpu_addr0_i ? `DMS_PLANES_ODD : `DMS_PLANES_EVEN; // R22
      // mask gates writes only; reads need every addressed plane
      if (cpu_we_i)
         cpu_planes = cpu_planes & cfg.mask;                           // R13
   end

   // bank pick: equal fields make the attribute bit irrelevant
   always_comb
   begin
      if (attribute_bit3_line_i)
         glyph_bank = cfg.glyph[`DMS_GLYPH_A_LO +: 2];                 // R17 R18
      else
         glyph_bank = cfg.glyph[`DMS_GLYPH_B_LO +: 2];                 // R16 R18
   end

   // next state of the whole sequencer
   always_comb
   begin
      d             = q;
      d.dot_tick    = 1'b0;
      d.char_clk    = 1'b0;
      d.serial_load = 1'b0;
      d.cpu_ack     = 1'b0;
      // high address outputs follow the layout register and the async run bit every cycle
      d.hi_oe = cfg.mem[`DMS_MEM_FULL] && cfg.run[`DMS_RUN_ASYNC];     // R21 R4
      if (!cfg.mem[`DMS_MEM_FULL])
      begin
         d.a_hi = 2'h0;                                                // R21
         d.b_hi = 2'h0;                                                // R19
      end
      else
      begin
         d.a_hi = crt_high_addr_i;
         if (cfg.mem[`DMS_MEM_ALPHA])
            d.b_hi = glyph_bank;                                       // R15
         else
            d.b_hi = crt_high_addr_i;                                  // R20
      end
      d.out_oe = cfg.run[`DMS_RUN_ASYNC];                              // R4
      if (!running)
      begin
         // halted: counters cleared, no memory cycles run
         d.div_ph  = 1'b0;                                             // R5
         d.dot_cnt = 4'h0;
         d.slot    = 3'h0;
         d.ld_ph   = 1'b0;
         d.crt_cyc = 1'b0;
         d.cpu_cyc = 1'b0;
         d.cpu_wr  = 1'b0;
         d.ras     = `DMS_PLANES_NONE;
         d.b_bus_column_strobe    = 1'b0;
         if (!cfg.run[`DMS_RUN_ASYNC])
         begin
            d.a_hi = 2'h0;                                             // R4
            d.b_hi = 2'h0;
         end
      end
      else
      begin
         d.div_ph = cfg.clk_cfg[`DMS_CLK_DIV2] ? !q.div_ph : 1'b0;     // R12
         if (dot_now)
         begin
            d.dot_tick = 1'b1;
            if (q.dot_cnt >= last_dot)
            begin
               // character boundary starts the next memory cycle
               d.dot_cnt     = 4'h0;                                   // R9
               d.char_clk    = 1'b1;
               d.ld_ph       = !q.ld_ph;
               d.serial_load = !cfg.clk_cfg[`DMS_CLK_LOAD2] || !q.ld_ph; // R11
               d.slot        = next_slot;
               d.crt_cyc     = q.slot < crt_slots;                     // R10
               d.cpu_cyc     = !(q.slot < crt_slots);                  // R10
               d.cpu_wr      = 1'b0;
               if (q.slot < crt_slots)
                  d.ras = `DMS_PLANES_ALL;
               else if (cpu_req_i)
               begin
                  d.ras     = cpu_planes;                              // R13 R22
                  d.cpu_wr  = cpu_we_i;
                  d.cpu_ack = 1'b1;
               end
               else
                  d.ras = `DMS_PLANES_NONE;
               d.b_bus_column_strobe = (q.slot < crt_slots) || cpu_req_i;
            end
            else
               d.dot_cnt = q.dot_cnt + 4'h1;
         end
      end
   end

   // state register
   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
      begin
         q <= '0;
      end
      else if (clk_en_i)
         q <= d;
   end

   // outputs straight from the state register
   assign dot_tick_o            = q.dot_tick;
   assign char_clk_o            = q.char_clk;
   assign serial_load_o         = q.serial_load;
   assign crt_cycle_o           = q.crt_cyc;
   assign cpu_cycle_o           = q.cpu_cyc;
   assign cpu_ack_o             = q.cpu_ack;
   assign b_bus_column_strobe_o = q.b_bus_column_strobe;
   assign a_bus_high_addr_14_o  = q.a_hi[0];
   assign a_bus_high_addr_15_o  = q.a_hi[1];
   assign b_bus_high_addr_14_o  = q.b_hi[0];
   assign b_bus_high_addr_15_o  = q.b_hi[1];
   assign high_addr_oe_o        = q.hi_oe;
   assign outputs_oe_o          = q.out_oe;

   // per-plane strobe fan-out
   logic [3:0] ras_out;
   for (genvar p = 0; p < 4; p++)
   begin : g_plane
      assign ras_out[p] = q.ras[p];
   end
   assign plane0_row_strobe_o = ras_out[0];
   assign plane1_row_strobe_o = ras_out[1];
   assign plane2_row_strobe_o = ras_out[2];
   assign plane3_row_strobe_o = ras_out[3];

   // character clock spacing sequences, undivided dot clock
   sequence s_gap8;
      (!q.char_clk)[*7] ##1 q.char_clk;
   endsequence

   sequence s_gap9;
      (!q.char_clk)[*8] ##1 q.char_clk;
   endsequence

   // a halted sequencer raises no row strobe
   a_halt_quiet: assert property (@(posedge core_clk_i) disable iff (sys_rst_i || !clk_en_i)
      !running |=> q.ras == `DMS_PLANES_NONE && !q.char_clk) // R5
      else $error("row strobe while halted");

   // async bit low floats every output
   a_async_float: assert property (@(posedge core_clk_i) disable iff (sys_rst_i || !clk_en_i)
      !cfg.run[`DMS_RUN_ASYNC] |-> ##NEXT_CYC (!q.out_oe && !q.hi_oe)) // R4
      else $error("outputs enabled during async reset");

   // eight dots per character
   // a legal halt in mid-character ends the check, so halting disables it
   a_char_eight: assert property (@(posedge core_clk_i) // R9
      disable iff (sys_rst_i || !clk_en_i || !running)
      (q.char_clk && running && cfg.clk_cfg == 4'h1) |=> s_gap8)
      else $error("character clock not 8 dots");

   // nine dots per character
   a_char_nine: assert property (@(posedge core_clk_i) // R9
      disable iff (sys_rst_i || !clk_en_i || !running)
      (q.char_clk && running && cfg.clk_cfg == 4'h0) |=> s_gap9)
      else $error("character clock not 9 dots");

   // crt owns the first slots of each group of five
   a_crt_share: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      q.char_clk |-> (q.crt_cyc == (q.slot != 3'h0 && q.slot <= crt_slots)
                      && q.crt_cyc != q.cpu_cyc)) // R10
      else $error("memory cycle owner wrong");

   // masked planes never strobe on a cpu write
   a_plane_mask: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      (q.cpu_cyc && q.cpu_wr) |-> (q.ras & ~cfg.mask) == `DMS_PLANES_NONE) // R13
      else $error("masked plane strobed");

   // odd/even mode never opens both halves of a pair
   a_odd_even: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      (q.cpu_cyc && !cfg.mem[`DMS_MEM_SEQ] && $stable(cfg.mem))
      |-> !(q.ras[0] && q.ras[1]) && !(q.ras[2] && q.ras[3])) // R22
      else $error("odd/even steering broken");

   // minimum memory keeps high bits at bank zero
   a_bank_zero: assert property (@(posedge core_clk_i) disable iff (sys_rst_i || !clk_en_i)
      !cfg.mem[`DMS_MEM_FULL] |=> (q.b_hi == 2'h0 && q.a_hi == 2'h0 && !q.hi_oe)) // R19 R21
      else $error("high address active in minimum memory");

   // graphics modes copy A high bits to B
   a_nonalpha_copy: assert property (@(posedge core_clk_i) disable iff (sys_rst_i || !clk_en_i)
      (running && cfg.mem[`DMS_MEM_FULL] && !cfg.mem[`DMS_MEM_ALPHA]) |=> q.b_hi == q.a_hi) // R20
      else $error("B high bits differ from A");

   // divided dot clock never ticks twice in a row
   a_dot_div: assert property (@(posedge core_clk_i) disable iff (sys_rst_i || !clk_en_i)
      (q.dot_tick && running && cfg.clk_cfg[`DMS_CLK_DIV2]) |=> !q.dot_tick) // R12
      else $error("dot clock not divided");

   // reload on every character when alternate load is off
   a_load_every: assert property (@(posedge core_clk_i) disable iff (sys_rst_i || !clk_en_i)
      (running && !cfg.clk_cfg[`DMS_CLK_LOAD2] && d.char_clk) |=> q.serial_load) // R11
      else $error("serializer reload missing");

endmodule

// ### tb/dms_host_model.sv
// host cpu model: indexed register writes and display memory requests
module dms_host_model (
   input  wire logic       core_clk_i,      // master clock
   input  wire logic       cpu_ack_i,       // grant pulse from the sequencer
   input  wire logic [3:0] row_strobes_i,   // plane strobes, seen at the grant
   output logic            wr_stb_o,        // register write strobe
   output logic            sel_o,           // 0 pointer, 1 data
   output logic [7:0]      data_o,          // register write data
   output logic            cpu_req_o,       // memory cycle request
   output logic            cpu_we_o,        // request is a write
   output logic            cpu_addr0_o      // odd/even address bit
);
   timeunit 1ns;
   timeprecision 1ps;

   // idle host, no request pending
   initial
   begin
      wr_stb_o    = 1'b0;
      sel_o       = 1'b0;
      data_o      = 8'h00;
      cpu_req_o   = 1'b0;
      cpu_we_o    = 1'b0;
      cpu_addr0_o = 1'b0;
   end

   // one write a pulse; data turned over after release so stale bytes never match
   task automatic reg_wr(input logic sel, input logic [7:0] d);
      @(posedge core_clk_i);
      wr_stb_o <= 1'b1;
      sel_o    <= sel;
      data_o   <= d;
      @(posedge core_clk_i);
      wr_stb_o <= 1'b0;
      data_o   <= ~d;
   endtask

   // pointer first, then the data byte
   task automatic set_reg(input logic [2:0] idx, input logic [7:0] val);
      reg_wr(1'b0, {5'h00, idx});
      reg_wr(1'b1, val);
   endtask

   // halt before touching clock settings so memory survives
   task automatic reprogram_clock(input logic [3:0] cfg);
      set_reg(3'h0, 8'h01);
      set_reg(3'h1, {4'h0, cfg});
      set_reg(3'h0, 8'h03);
   endtask

   // request held until the grant is seen at a rising edge
   task automatic cpu_access(input logic we, input logic a0, output logic [4:0] got);
      int n;
      n = 0;
      @(posedge core_clk_i);
      cpu_req_o   <= 1'b1;
      cpu_we_o    <= we;
      cpu_addr0_o <= a0;
      do
      begin
         @(posedge core_clk_i);
         n++;
      end
      while (cpu_ack_i !== 1'b1 && n < 400);
      got         = {cpu_ack_i, row_strobes_i};
      cpu_req_o   <= 1'b0;
      cpu_we_o    <= ~we;
      cpu_addr0_o <= ~a0;
   endtask
endmodule

// ### tb/test_dms_sequencer.sv
// self-checking bench of the display memory sequencer
module test_dms_sequencer;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct packed {
      logic [1:0]  kind;    // 0 timing, 1 cpu strobes, 2 high address
      logic [3:0]  cfg;
      logic [3:0]  mask;
      logic [2:0]  layout;
      logic [3:0]  glyph;
      logic [2:0]  ctl;     // we, addr0, attribute
      logic [1:0]  crt;
      logic [15:0] want;
   } dms_row_t;

   // timing: period, crt per 10, loads per 10; cpu: {ack, strobes}; address: {care, oe a b}
   localparam dms_row_t rows [18] = '{
      '{2'd0, 4'h0, 4'hf, 3'h0, 4'h0, 3'h0, 2'h0, 16'h098a},
      '{2'd0, 4'h1, 4'hf, 3'h0, 4'h0, 3'h0, 2'h0, 16'h088a},
      '{2'd0, 4'h3, 4'hf, 3'h0, 4'h0, 3'h0, 2'h0, 16'h084a},
      '{2'd0, 4'h5, 4'hf, 3'h0, 4'h0, 3'h0, 2'h0, 16'h0885},
      '{2'd0, 4'h9, 4'hf, 3'h0, 4'h0, 3'h0, 2'h0, 16'h108a},
      '{2'd0, 4'h8, 4'hf, 3'h0, 4'h0, 3'h0, 2'h0, 16'h128a},
      '{2'd1, 4'h3, 4'hf, 3'h4, 4'h0, 3'h4, 2'h0, 16'h001f},
      '{2'd1, 4'h3, 4'h3, 3'h4, 4'h0, 3'h4, 2'h0, 16'h0013},
      '{2'd1, 4'h3, 4'h3, 3'h0, 4'h0, 3'h4, 2'h0, 16'h0011},
      '{2'd1, 4'h3, 4'h3, 3'h0, 4'h0, 3'h6, 2'h0, 16'h0012},
      '{2'd1, 4'h3, 4'h0, 3'h4, 4'h0, 3'h0, 2'h0, 16'h001f},
      '{2'd1, 4'h3, 4'h0, 3'h0, 4'h0, 3'h2, 2'h0, 16'h001a},
      '{2'd1, 4'h3, 4'h0, 3'h4, 4'h0, 3'h4, 2'h0, 16'h0010},
      '{2'd2, 4'h1, 4'hf, 3'h2, 4'he, 3'h1, 2'h1, 16'h1f15},
      '{2'd2, 4'h1, 4'hf, 3'h3, 4'h6, 3'h0, 2'h3, 16'h1f1e},
      '{2'd2, 4'h1, 4'hf, 3'h3, 4'h6, 3'h1, 2'h3, 16'h1f1d},
      '{2'd2, 4'h1, 4'hf, 3'h3, 4'h5, 3'h0, 2'h2, 16'h1f19},
      '{2'd2, 4'h1, 4'hf, 3'h1, 4'h6, 3'h1, 2'h2, 16'h1f00}
   };

   logic       core_clk_i;
   logic       sys_rst_i;
   logic       clk_en_i;
   logic       attr;
   logic [1:0] crt_hi;
   logic       wr_stb, sel, cpu_req, cpu_we, cpu_a0;
   logic [7:0] wr_data;
   logic       dot, chr, load, crt_cyc, cpu_cyc, ack, b_bus_column_strobe;
   logic [3:0] ras;
   logic [1:0] a_hi, b_hi;
   logic       hi_oe, out_oe;
   int         errors;
   int         checked;

   // master clock, 25 ns period
   initial
   begin
      core_clk_i = 1'b0;
      forever #12.5 core_clk_i = ~core_clk_i;
   end

   dms_host_model host (
      .core_clk_i(core_clk_i), .cpu_ack_i(ack), .row_strobes_i(ras), .wr_stb_o(wr_stb),
      .sel_o(sel), .data_o(wr_data), .cpu_req_o(cpu_req), .cpu_we_o(cpu_we),
      .cpu_addr0_o(cpu_a0)
   );

   dms_sequencer uut (
      .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i),
      .wr_stb_i(wr_stb), .index_select_input_i(sel), .wr_data_i(wr_data),
      .cpu_req_i(cpu_req), .cpu_we_i(cpu_we), .cpu_addr0_i(cpu_a0),
      .attribute_bit3_line_i(attr), .crt_high_addr_i(crt_hi), .dot_tick_o(dot),
      .char_clk_o(chr), .serial_load_o(load), .crt_cycle_o(crt_cyc), .cpu_cycle_o(cpu_cyc),
      .cpu_ack_o(ack), .plane0_row_strobe_o(ras[0]), .plane1_row_strobe_o(ras[1]),
      .plane2_row_strobe_o(ras[2]), .plane3_row_strobe_o(ras[3]),
      .b_bus_column_strobe_o(b_bus_column_strobe), .a_bus_high_addr_14_o(a_hi[0]),
      .a_bus_high_addr_15_o(a_hi[1]), .b_bus_high_addr_14_o(b_hi[0]),
      .b_bus_high_addr_15_o(b_hi[1]), .high_addr_oe_o(hi_oe), .outputs_oe_o(out_oe)
   );

   task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp)
      begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic finish_test();
      if (errors == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // ten characters from one boundary: period, crt slots and reload pulses
   task automatic measure(output logic [15:0] res);
      int cyc, n, crt, ld;
      cyc = 0;
      n = 0;
      crt = 0;
      ld = 0;
      while (chr !== 1'b1 && cyc < 100)
      begin
         @(posedge core_clk_i);
         cyc++;
      end
      cyc = 0;
      while (n < 10 && cyc < 400)
      begin
         @(posedge core_clk_i);
         cyc++;
         n   += (chr === 1'b1) ? 1 : 0;
         crt += (chr === 1'b1 && crt_cyc === 1'b1) ? 1 : 0;
         ld  += (load === 1'b1) ? 1 : 0;
      end
      res = {8'(cyc / 10), 4'(crt), 4'(ld)};
   endtask

   // character boundaries seen within a span
   task automatic count_chars(output logic [15:0] n);
      n = 16'h0000;
      repeat (40)
      begin
         @(posedge core_clk_i);
         n += (chr === 1'b1) ? 16'h0001 : 16'h0000;
      end
   endtask

   // a hang counts against the run
   initial
   begin
      #500us;
      errors++;
      finish_test();
   end

   initial
   begin
      logic [15:0] res;
      logic [4:0]  got;
      errors = 0;
      checked = 0;
      sys_rst_i = 1'b1;
      clk_en_i = 1'b1;
      attr = 1'b0;
      crt_hi = 2'h0;
      repeat (6) @(posedge core_clk_i);
      check_val({15'h0, out_oe}, 16'h0000);
      sys_rst_i <= 1'b0;
      foreach (rows[i])
      begin
         host.reprogram_clock(rows[i].cfg);
         host.set_reg(3'h2, {4'h0, rows[i].mask});
         host.set_reg(3'h3, {4'h0, rows[i].glyph});
         host.set_reg(3'h4, {5'h00, rows[i].layout});
         attr   <= rows[i].ctl[0];
         crt_hi <= rows[i].crt;
         if (rows[i].kind == 2'd0)
         begin
            measure(res);
            check_val(res, rows[i].want);
         end
         else if (rows[i].kind == 2'd1)
         begin
            host.cpu_access(rows[i].ctl[2], rows[i].ctl[1], got);
            check_val({11'h0, got}, rows[i].want);
            check_val({14'h0, cpu_cyc, b_bus_column_strobe}, 16'h0003);
         end
         else
         begin
            repeat (3) @(posedge core_clk_i);
            res = {11'h0, hi_oe, a_hi, b_hi} & {8'h0, rows[i].want[15:8]};
            check_val(res, {8'h0, rows[i].want[7:0]});
         end
      end
      // halted by the sync bit: no characters, pins still driven
      host.set_reg(3'h0, 8'h01);
      // the halt acts one cycle after the write edge
      @(posedge core_clk_i);
      count_chars(res);
      check_val(res, 16'h0000);
      check_val({15'h0, out_oe}, 16'h0001);
      check_val({14'h0, dot, b_bus_column_strobe}, 16'h0000);
      // pointer kept: a lone data write restarts the sequencer
      host.reg_wr(1'b1, 8'h03);
      count_chars(res);
      check_val({15'h0, res != 16'h0000}, 16'h0001);
      // async bit low floats outputs and clears the bank choice
      host.set_reg(3'h3, 8'h06);
      host.set_reg(3'h4, 8'h03);
      attr <= 1'b0;
      host.set_reg(3'h0, 8'h02);
      repeat (3) @(posedge core_clk_i);
      check_val({14'h0, out_oe, hi_oe}, 16'h0000);
      host.reg_wr(1'b1, 8'h03);
      repeat (3) @(posedge core_clk_i);
      check_val({13'h0, hi_oe, b_hi}, 16'h0004);
      // frozen clock enable stops everything; freeze right after a pulse ends
      while (chr !== 1'b1) @(posedge core_clk_i);
      clk_en_i <= 1'b0;
      count_chars(res);
      check_val(res, 16'h0000);
      clk_en_i <= 1'b1;
      finish_test();
   end
endmodule
